// ===== logic/spc_defs.svh
// Register offsets, field positions, reset values and timing figures of the SYSREF control block
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// Register offsets on the serial port
`define SPC_ADDR_FREQ_DIV      7'h18
`define SPC_ADDR_PWR_SYNC      7'h19
`define SPC_ADDR_PULSE_COUNT   7'h1a
`define SPC_ADDR_GLOBAL_DELAY  7'h1b
`define SPC_ADDR_KEY_HI_MODE   7'h1c
`define SPC_ADDR_KEY_LO_MISC   7'h1f
`define SPC_ADDR_TRIGGER       7'h70

// Field positions
`define SPC_PD_BIT             7
`define SPC_BIAS_BIT           6
`define SPC_PIN_CHOICE_BIT     2
`define SPC_SRC_EXT_BIT        1
`define SPC_CONT_BIT           0
`define SPC_TRIGGER_BIT        7

// Reset values
`define SPC_RST_FREQ_DIV       8'h00
`define SPC_RST_SYNC_CODE      6'h11
`define SPC_RST_PD             1'b0
`define SPC_RST_BIAS           1'b1
`define SPC_RST_PULSE_COUNT    8'h02
`define SPC_RST_GLOBAL_DELAY   8'h00
`define SPC_RST_NIBBLE         4'h0

// Modification key and VCXO output startup configuration
`define SPC_VCXO_KEY           8'h4b
`define SPC_VCXO_BOOT_POWER    1'b1
`define SPC_VCXO_BOOT_FORMAT   1'b1
`define SPC_VCXO_BOOT_AMPL     2'h3

// Timing: delay step and clock period in ps
`define SPC_DLY_STEP_PS        814
`define SPC_CLK_PERIOD_PS      4000

// Serial frame: read flag, 7 address bits, 8 data bits
`define SPC_SPI_ADDR_LAST      5'h07
`define SPC_SPI_FRAME_LAST     5'h0f
`define SPC_SPI_FRAME_BITS     5'h10

`endif

// ===== logic/spc_pkg.sv
// Types shared by the SYSREF control block modules
package spc_pkg;

    typedef enum logic [1:0] {
        SPC_GEN_IDLE  = 2'b00,
        SPC_GEN_ARM   = 2'b01,
        SPC_GEN_BURST = 2'b10
    } spc_gen_t;

    typedef struct packed {
        logic       sclk_q;
        logic [4:0] bit_cnt;
        logic [6:0] shin;
        logic [7:0] shout;
        logic       rnw;
        logic       sdo;
        logic       wr_stb;
        logic [6:0] addr;
        logic [7:0] wdata;
    } spc_spi_state_t;

    typedef struct packed {
        logic [4:0][3:0] cnt;
        logic            wave;
    } spc_div_state_t;

    typedef struct packed {
        logic [7:0]  div_setting;
        logic        pd;
        logic        bias;
        logic [5:0]  sync_code;
        logic [7:0]  burst_len;
        logic [7:0]  delay_code;
        logic [3:0]  key_hi;
        logic        pin_choice;
        logic        src_ext;
        logic        continuous;
        logic [3:0]  misc_hi;
        logic [3:0]  key_lo;
        spc_gen_t    gen;
        logic [7:0]  left;
        logic [7:0]  sync_cnt;
        logic        sync_tick;
        logic        wave_q;
        logic        ext_q;
        logic        div_run;
        logic [5:0]  dly;
        logic [63:0] hist;
        logic        sysref_out;
        logic        crosspoint;
        logic        powered;
        logic        busy;
        logic        vcxo_pwr;
        logic        vcxo_fmt;
        logic [1:0]  vcxo_ampl;
    } spc_main_state_t;

endpackage

// ===== logic/spc_reg_if.sv
// Register access path between the serial slave and the register file
`timescale 1ns/1ps
interface spc_reg_if;
    logic       wr_stb;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport port (output wr_stb, output addr, output wdata, input rdata);
    modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface

// ===== logic/spc_spi_slave.sv
// Serial port slave: 16-bit frames of read flag, address and data
`timescale 1ns/1ps
`include "spc_defs.svh"
module spc_spi_slave (
    input  wire logic  clock,
    input  wire logic  rst_n,
    input  wire logic  spi_cs_n,
    input  wire logic  spi_sclk,
    input  wire logic  spi_sdi,
    output logic       spi_sdo,
    spc_reg_if.port    bus
);
    spc_pkg::spc_spi_state_t s;
    spc_pkg::spc_spi_state_t next_s;

    // Bits are taken on SCLK rising and read data shifts out on SCLK falling
    always_comb begin
        next_s        = s;
        next_s.wr_stb = 1'b0;
        next_s.sclk_q = spi_sclk;
        if (spi_cs_n) begin
            next_s.bit_cnt = 5'h00;
            next_s.sdo     = 1'b0;
        end else if (spi_sclk && !s.sclk_q && s.bit_cnt != `SPC_SPI_FRAME_BITS) begin
            next_s.shin    = {s.shin[5:0], spi_sdi};
            next_s.bit_cnt = s.bit_cnt + 5'h01;
            if (s.bit_cnt == `SPC_SPI_ADDR_LAST) begin
                next_s.rnw  = s.shin[6];
                next_s.addr = {s.shin[5:0], spi_sdi};
            end
            if (s.bit_cnt == `SPC_SPI_FRAME_LAST && !s.rnw) begin
                next_s.wdata  = {s.shin[6:0], spi_sdi};
                next_s.wr_stb = 1'b1;
            end
        end else if (!spi_sclk && s.sclk_q && s.rnw) begin
            // Reads are loaded once the address is complete
            if (s.bit_cnt == 5'h08) begin
                next_s.sdo   = bus.rdata[7];
                next_s.shout = {bus.rdata[6:0], 1'b0};
            end else if (s.bit_cnt > 5'h08 && s.bit_cnt < `SPC_SPI_FRAME_BITS) begin
                next_s.sdo   = s.shout[7];
                next_s.shout = {s.shout[6:0], 1'b0};
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign spi_sdo    = s.sdo;
    assign bus.wr_stb = s.wr_stb;
    assign bus.addr   = s.addr;
    assign bus.wdata  = s.wdata;
endmodule

// ===== logic/spc_ref_divider.sv
// Five cascaded SYSREF divider stages and a final divide by two
`timescale 1ns/1ps
module spc_ref_divider (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [7:0] setting,
    output logic            wave
);
    spc_pkg::spc_div_state_t s;
    spc_pkg::spc_div_state_t next_s;
    logic [5:0]              carry;
    logic [4:0]              wrap;

    // Ratio of one stage from its field of the divider setting
    function automatic logic [4:0] stage_ratio(input int idx, input logic [7:0] ns);
        logic [4:0] r;
        r = 5'h02;
        case (idx)
            0:       r = 5'h02 + {3'h0, ns[1:0]};          // 2,3,4,5
            1:       r = ns[2] ? 5'h04 : 5'h02;
            2:       r = ns[3] ? 5'h04 : 5'h02;
            3:       r = 5'h02 + {3'h0, ns[5:4]};
            4:       r = 5'h02 << ns[7:6];                 // 2,4,8,16
            default: r = 5'h02;
        endcase
        return r;
    endfunction

    // Each stage advances when all lower stages wrap
    assign carry[0] = run;
    for (genvar i = 0; i < 5; i++) begin : g_stage
        assign wrap[i]      = s.cnt[i] == 4'(stage_ratio(i, setting) - 5'h01);
        assign carry[i + 1] = carry[i] && wrap[i];
    end

    // The final stage toggles the output, doubling the total ratio
    always_comb begin
        next_s = s;
        if (!run) begin
            next_s = '0;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (carry[i]) begin
                    next_s.cnt[i] = wrap[i] ? 4'h0 : s.cnt[i] + 4'h1;
                end
            end
            if (carry[5]) begin
                next_s.wave = !s.wave;
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign wave = s.wave;
endmodule

// ===== logic/spc_sysref_control.sv
// SYSREF pulse control: registers, burst generation, delay, bias and VCXO key gate
//
// Summary of operation
// - Power-down bit set stops the SYSREF divider, synchronizer, burst sequencer and delay line; cross-point bias still follows idle force.
// - SYSREF divider ratio is two times the product of five stages.
// - Bias bit picks cross-point or static idle level when forced or during events.
// - Synchronizer divider code resets to 010001 for divide by 30; zero unused.
// - Counted mode emits pulse-count pulses per trigger, 1 to 255, reset 2.
// - Global delay adds field times 814 ps, rounded up to whole 4000 ps clock cycles, to the SYSREF output.
// - Source bit chooses internal trigger generation or external pin following.
// - Mode bit chooses counted bursts or continuous pulses.
// - Pin choice bit selects dedicated external pin or second clock input.
// - Writing trigger one releases the burst; it is ignored while the power-down bit is set.
// - Trigger acts only in internal counted mode.
// - Trigger aligns SYSREF to device clock and loads the delay value.
// - Without the key the VCXO output keeps LVPECL, 750 mV, powered on.
// - Any other key value blocks VCXO output setting changes.
// - After startup the VCXO output is on, LVPECL, 750 mV until keyed.
`timescale 1ns/1ps
`include "spc_defs.svh"
module spc_sysref_control (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_sclk,
    input  wire logic       spi_sdi,
    output logic            spi_sdo,
    input  wire logic       external_sysref_pin,
    input  wire logic       clk1_sysref_in,
    input  wire logic       output_idle_force,
    input  wire logic       vcxo_out_power_on,
    input  wire logic       vcxo_out_format,
    input  wire logic [1:0] vcxo_out_amplitude,
    output logic            sysref_output,
    output logic            sysref_bias_crosspoint,
    output logic            sysref_powered,
    output logic            sysref_busy,
    output logic            vcxo_power_on_eff,
    output logic            vcxo_format_eff,
    output logic [1:0]      vcxo_amplitude_eff,
    output logic [3:0]      misc_control
);
    spc_pkg::spc_main_state_t s;
    spc_pkg::spc_main_state_t next_s;
    spc_reg_if                rbus ();
    logic                     wave;
    logic                     trig;
    logic                     internal_counted;
    logic                     wave_fall;
    logic                     raw;
    logic [7:0]               rdata;

    // Synchronizer divider ratio from its code; unlisted codes fall back to code plus one
    function automatic logic [7:0] sync_ratio(input logic [5:0] code);
        logic [7:0] r;
        r = {2'h0, code} + 8'h01;
        case (code)
            6'h05:   r = 8'h06;
            6'h06:   r = 8'h08;
            6'h07:   r = 8'h09;
            6'h11:   r = 8'h1e;            // Divide by 30
            6'h12:   r = 8'h20;
            6'h1a:   r = 8'h32;
            6'h1d:   r = 8'h60;
            6'h20:   r = 8'h80;
            6'h21:   r = 8'h96;
            6'h00:   r = 8'h02;            // Forbidden code, kept harmless
            default: r = {2'h0, code} + 8'h01;
        endcase
        return r;
    endfunction

    // Delay code to whole clock cycles, rounded up to the next cycle
    function automatic logic [5:0] delay_cycles(input logic [7:0] code);
        logic [17:0] ps;
        ps = 18'(code) * 18'(`SPC_DLY_STEP_PS);
        return 6'((ps + 18'(`SPC_CLK_PERIOD_PS - 1)) / 18'(`SPC_CLK_PERIOD_PS));
    endfunction

    spc_spi_slave u_spi (
        .clock    (clock),
        .rst_n    (rst_n),
        .spi_cs_n (spi_cs_n),
        .spi_sclk (spi_sclk),
        .spi_sdi  (spi_sdi),
        .spi_sdo  (spi_sdo),
        .bus      (rbus.port)
    );

    spc_ref_divider u_div (
        .clock   (clock),
        .rst_n   (rst_n),
        .run     (s.div_run),
        .setting (s.div_setting),
        .wave    (wave)
    );

    // Read mux; trigger register and unmapped addresses read zero
    always_comb begin
        case (rbus.addr)
            `SPC_ADDR_FREQ_DIV:     rdata = s.div_setting;
            `SPC_ADDR_PWR_SYNC:     rdata = {s.pd, s.bias, s.sync_code};
            `SPC_ADDR_PULSE_COUNT:  rdata = s.burst_len;
            `SPC_ADDR_GLOBAL_DELAY: rdata = s.delay_code;
            `SPC_ADDR_KEY_HI_MODE:  rdata = {s.key_hi, 1'b0, s.pin_choice, s.src_ext, s.continuous};
            `SPC_ADDR_KEY_LO_MISC:  rdata = {s.misc_hi, s.key_lo};
            default:                rdata = 8'h00;     // Trigger is write-only
        endcase
    end
    assign rbus.rdata = rdata;

    // Trigger is a one-cycle strobe, never stored, so a write arriving outside IDLE is lost
    assign trig = rbus.wr_stb && rbus.addr == `SPC_ADDR_TRIGGER
                  && rbus.wdata[`SPC_TRIGGER_BIT];
    assign internal_counted = !s.src_ext && !s.continuous;
    assign wave_fall        = s.wave_q && !wave;

    // Source of the undelayed SYSREF signal
    always_comb begin
        if (s.pd) begin
            raw = 1'b0;
        end else if (s.src_ext) begin
            raw = s.ext_q;
        end else if (s.continuous) begin
            raw = wave;
        end else begin
            raw = wave && s.gen == spc_pkg::SPC_GEN_BURST;
        end
    end

    // Next state
    always_comb begin
        next_s        = s;
        next_s.wave_q = wave;

        // Register writes
        if (rbus.wr_stb) begin
            case (rbus.addr)
                `SPC_ADDR_FREQ_DIV: begin
                    next_s.div_setting = rbus.wdata;
                end
                `SPC_ADDR_PWR_SYNC: begin
                    next_s.pd        = rbus.wdata[`SPC_PD_BIT];
                    next_s.bias      = rbus.wdata[`SPC_BIAS_BIT];
                    next_s.sync_code = rbus.wdata[5:0];
                end
                `SPC_ADDR_PULSE_COUNT: begin
                    next_s.burst_len = rbus.wdata;
                end
                `SPC_ADDR_GLOBAL_DELAY: begin
                    next_s.delay_code = rbus.wdata;
                end
                `SPC_ADDR_KEY_HI_MODE: begin
                    next_s.key_hi     = rbus.wdata[7:4];
                    next_s.pin_choice = rbus.wdata[`SPC_PIN_CHOICE_BIT];
                    next_s.src_ext    = rbus.wdata[`SPC_SRC_EXT_BIT];
                    next_s.continuous = rbus.wdata[`SPC_CONT_BIT];
                end
                `SPC_ADDR_KEY_LO_MISC: begin
                    next_s.misc_hi = rbus.wdata[7:4];
                    next_s.key_lo  = rbus.wdata[3:0];
                end
                default: begin
                end
            endcase
        end

        // External pin retimed once; choice between dedicated pin and second clock input
        next_s.ext_q = s.pin_choice ? clk1_sysref_in : external_sysref_pin;

        // Synchronizer divider marks clock edges where all outputs coincide
        next_s.sync_tick = 1'b0;
        if (s.pd) begin
            next_s.sync_cnt = 8'h00;
        end else if (s.sync_cnt >= sync_ratio(s.sync_code) - 8'h01) begin
            next_s.sync_cnt  = 8'h00;
            next_s.sync_tick = 1'b1;
        end else begin
            next_s.sync_cnt = s.sync_cnt + 8'h01;
        end

        // Burst sequencer
        case (s.gen)
            spc_pkg::SPC_GEN_IDLE: begin
                if (trig && internal_counted && !s.pd && s.burst_len != 8'h00) begin
                    next_s.gen  = spc_pkg::SPC_GEN_ARM;
                    next_s.left = s.burst_len;
                    next_s.dly  = delay_cycles(s.delay_code);
                end
            end
            spc_pkg::SPC_GEN_ARM: begin
                // Waiting for a coincident edge keeps SYSREF aligned to the device clock
                if (s.sync_tick) begin
                    next_s.gen = spc_pkg::SPC_GEN_BURST;
                end
            end
            spc_pkg::SPC_GEN_BURST: begin
                if (wave_fall) begin
                    next_s.left = s.left - 8'h01;
                    if (s.left == 8'h01) begin
                        next_s.gen = spc_pkg::SPC_GEN_IDLE;
                    end
                end
            end
            default: begin
                next_s.gen = spc_pkg::SPC_GEN_IDLE;
            end
        endcase
        // A mode change or power-down abandons any burst in progress
        if (s.pd || !internal_counted) begin
            next_s.gen  = spc_pkg::SPC_GEN_IDLE;
            next_s.left = 8'h00;
        end

        // Outside counted mode the delay follows the register directly
        if (!internal_counted) begin
            next_s.dly = delay_cycles(s.delay_code);
        end

        // Divider restarts from phase zero at each burst start
        next_s.div_run = !s.pd && ((!s.src_ext && s.continuous)
                         || next_s.gen == spc_pkg::SPC_GEN_BURST);

        // Global delay line: history of the raw signal, tapped by the loaded delay
        next_s.hist = s.pd ? 64'h0 : {s.hist[62:0], raw};
        if (s.dly == 6'h00) begin
            next_s.sysref_out = raw;
        end else begin
            next_s.sysref_out = s.hist[s.dly - 6'h01];
        end

        // Cross-point bias only when bias type is set and the output is forced or active
        next_s.crosspoint = s.bias && (output_idle_force || raw || s.gen != spc_pkg::SPC_GEN_IDLE);

        next_s.powered = !s.pd;
        next_s.busy    = next_s.gen != spc_pkg::SPC_GEN_IDLE;

        // VCXO output settings pass only while the key is in place
        if ({s.key_hi, s.key_lo} == `SPC_VCXO_KEY) begin
            next_s.vcxo_pwr  = vcxo_out_power_on;
            next_s.vcxo_fmt  = vcxo_out_format;
            next_s.vcxo_ampl = vcxo_out_amplitude;
        end else begin
            next_s.vcxo_pwr  = `SPC_VCXO_BOOT_POWER;
            next_s.vcxo_fmt  = `SPC_VCXO_BOOT_FORMAT;
            next_s.vcxo_ampl = `SPC_VCXO_BOOT_AMPL;
        end
    end

    // State register with documented power-up values
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s             <= '0;
            s.div_setting <= `SPC_RST_FREQ_DIV;
            s.pd          <= `SPC_RST_PD;
            s.bias        <= `SPC_RST_BIAS;
            s.sync_code   <= `SPC_RST_SYNC_CODE;
            s.burst_len   <= `SPC_RST_PULSE_COUNT;
            s.delay_code  <= `SPC_RST_GLOBAL_DELAY;
            s.key_hi      <= `SPC_RST_NIBBLE;
            s.key_lo      <= `SPC_RST_NIBBLE;
            s.gen         <= spc_pkg::SPC_GEN_IDLE;
            s.powered     <= 1'b1;
            s.vcxo_pwr    <= `SPC_VCXO_BOOT_POWER;
            s.vcxo_fmt    <= `SPC_VCXO_BOOT_FORMAT;
            s.vcxo_ampl   <= `SPC_VCXO_BOOT_AMPL;
        end else begin
            s <= next_s;
        end
    end

    assign sysref_output          = s.sysref_out;
    assign sysref_bias_crosspoint = s.crosspoint;
    assign sysref_powered         = s.powered;
    assign sysref_busy            = s.busy;
    assign vcxo_power_on_eff      = s.vcxo_pwr;
    assign vcxo_format_eff        = s.vcxo_fmt;
    assign vcxo_amplitude_eff     = s.vcxo_ampl;
    assign misc_control           = s.misc_hi;
endmodule

// ===== bench/spc_converter_model.sv
// Converter model: counts SYSREF rises and the spacing of the last two
`timescale 1ns/1ps
module spc_converter_model (
    input  wire logic   clock,
    input  wire logic   rst_n,
    input  wire logic   sysref_output,
    output logic [15:0] edges,
    output logic [15:0] period
);
    logic        last;
    logic [15:0] since;
    // Captured on the device clock, as a converter would sample SYSREF
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {last, edges, period, since} <= '0;
        end else begin
            last <= sysref_output;
            since <= (sysref_output && !last) ? 16'h0001 : since + 16'h0001;
            if (sysref_output && !last) begin
                edges <= edges + 16'h0001;
                period <= since;
            end
        end
    end
endmodule

// ===== bench/spc_sysref_monitor.sv
// Port-level assertions for the SYSREF control block
`timescale 1ns/1ps
module spc_sysref_monitor (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       spi_cs_n,
    input wire logic       vcxo_out_power_on,
    input wire logic       vcxo_out_format,
    input wire logic [1:0] vcxo_out_amplitude,
    input wire logic       sysref_output,
    input wire logic       sysref_powered,
    input wire logic       sysref_busy,
    input wire logic       vcxo_power_on_eff,
    input wire logic       vcxo_format_eff,
    input wire logic [1:0] vcxo_amplitude_eff
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [3:0] eff;
    logic [3:0] raw;
    // Boot config packs to all ones: on, LVPECL, 750 mV
    assign eff = {vcxo_power_on_eff, vcxo_format_eff, vcxo_amplitude_eff};
    assign raw = {vcxo_out_power_on, vcxo_out_format, vcxo_out_amplitude};
    startup_cfg_a: assert property ($rose(rst_n) |-> eff == 4'hf && sysref_powered && !sysref_busy)
        else $error("outputs not at startup values");
    vcxo_follow_a: assert property (eff != 4'hf |-> eff == $past(raw))
        else $error("vcxo config neither boot nor keyed copy");
    pd_idle_a: assert property (!sysref_powered [*8] |-> !sysref_busy)
        else $error("burst while powered down");
    power_write_a: assert property ($changed(sysref_powered) |-> !$past(spi_cs_n, 2))
        else $error("power state changed without a write");
    trig_start_a: assert property ($rose(sysref_busy) |-> sysref_powered && !$past(spi_cs_n, 2))
        else $error("burst started without a trigger write");
    busy_min_a: assert property ($rose(sysref_busy) |-> sysref_busy [*8])
        else $error("burst ended too early");
    pulse_high_a: assert property ($rose(sysref_output) |-> sysref_output [*8])
        else $error("sysref high phase too short");
    pulse_low_a: assert property ($fell(sysref_output) |-> !sysref_output [*8])
        else $error("sysref low phase too short");
    // Main scenarios reached
    cover property ($rose(sysref_busy));
    cover property (eff != 4'hf);
    cover property ($fell(sysref_powered));
endmodule
bind spc_sysref_control spc_sysref_monitor u_mon (.clock(clock), .rst_n(rst_n), .spi_cs_n(spi_cs_n),
    .vcxo_out_power_on(vcxo_out_power_on), .vcxo_out_format(vcxo_out_format),
    .vcxo_out_amplitude(vcxo_out_amplitude), .sysref_output(sysref_output), .sysref_powered(sysref_powered),
    .sysref_busy(sysref_busy), .vcxo_power_on_eff(vcxo_power_on_eff), .vcxo_format_eff(vcxo_format_eff),
    .vcxo_amplitude_eff(vcxo_amplitude_eff));

// ===== bench/tb_sysref_pulse_control.sv
// Self-checking bench for the SYSREF control block
`timescale 1ns/1ps
module tb_sysref_pulse_control;
    logic        clock, rst_n, cs_n, sclk, sdi, ext_pin, clk1_in, force_idle;
    logic        sdo, sref, xp, pwr, busy;
    logic [3:0]  raw, eff, misc;
    logic [15:0] edges, per, act;
    logic [15:0] q_exp[$];
    logic [7:0]  rd;
    logic [6:0]  ra[8] = '{7'h18, 7'h19, 7'h1a, 7'h1b, 7'h1c, 7'h1f, 7'h70, 7'h05};
    logic [7:0]  re[8] = '{8'h00, 8'h51, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int          n_mismatch, n_compared, l0, l1, n, d;
    event        got;

    spc_sysref_control dut (.clock(clock), .rst_n(rst_n), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdi(sdi),
        .spi_sdo(sdo), .external_sysref_pin(ext_pin), .clk1_sysref_in(clk1_in), .output_idle_force(force_idle),
        .vcxo_out_power_on(raw[3]), .vcxo_out_format(raw[2]), .vcxo_out_amplitude(raw[1:0]),
        .sysref_output(sref), .sysref_bias_crosspoint(xp), .sysref_powered(pwr), .sysref_busy(busy),
        .vcxo_power_on_eff(eff[3]), .vcxo_format_eff(eff[2]), .vcxo_amplitude_eff(eff[1:0]), .misc_control(misc));
    spc_converter_model adc (.clock(clock), .rst_n(rst_n), .sysref_output(sref), .edges(edges), .period(per));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Inputs always change 1 ns after the rising edge
    task cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    // One frame, MSB first; sclk phases of 3 clocks keep it slow enough for the sampler
    task xfer(input logic r, input logic [6:0] a, input logic [7:0] w);
        logic [15:0] f;
        f = {r, a, w};
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi = f[i];
            cyc(3);
            if (i < 8) rd[i] = sdo;
            sclk = 1'b1;
            cyc(3);
            sclk = 1'b0;
        end
        cyc(3);
        cs_n = 1'b1;
        cyc(3);
    endtask
    task chk(input logic [15:0] a, input logic [15:0] e);
        q_exp.push_back(e);
        act = a;
        ->got;
        #0;
    endtask
    // Watcher: takes the oldest note whenever a result is posted
    always @(got) begin
        n_compared++;
        if (act !== q_exp[0]) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, act, q_exp[0]);
        end
        void'(q_exp.pop_front());
    end
    task trig(input int cnt, input int p, input bit again);
        int c0;
        c0 = edges;
        xfer(0, 7'h70, 8'h80);
        chk(busy, 1);
        if (again) xfer(0, 7'h70, 8'h80);
        for (int k = 0; k < 20000 && busy !== 1'b0; k++) cyc(1);
        cyc(80);
        chk(edges - c0[15:0], cnt[15:0]);
        chk(per, p[15:0]);
    endtask
    // Pin-to-output latency on the external path; pin held long past the rise
    task lat(output int l);
        ext_pin = 1'b1;
        l = 0;
        while (sref !== 1'b1 && l < 100) begin
            cyc(1);
            l++;
        end
        cyc(10);
        ext_pin = 1'b0;
        cyc(80);
    endtask
    task conclude;
        $display("counts: %0d compared, %0d mismatches", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog well beyond the expected run of about 6k cycles
    initial begin
        #400000;
        n_mismatch++;
        conclude();
    end
    initial begin
        {rst_n, cs_n, sclk, sdi, ext_pin, clk1_in, force_idle} = 7'h20;
        raw = 4'h0;
        n_mismatch = 0;
        n_compared = 0;
        void'($urandom(91400));
        cyc(5);
        rst_n = 1'b1;
        cyc(2);
        chk({pwr, busy, eff, misc}, {1'b1, 1'b0, 4'hf, 4'h0});
        foreach (ra[i]) begin
            xfer(1, ra[i], 8'h00);
            chk(rd, re[i]);
        end
        $display("test reset values done");
        raw = {1'b0, 3'($urandom)};
        xfer(0, 7'h1c, 8'h40);
        chk(eff, 4'hf);
        xfer(0, 7'h1f, 8'hab);
        chk({eff, misc}, {raw, 4'ha});
        raw = raw ^ 4'h5;
        cyc(2);
        chk(eff, raw);
        xfer(0, 7'h1c, 8'h00);
        chk(eff, 4'hf);
        $display("test vcxo key done");
        trig(2, 64, 0);
        xfer(0, 7'h1c, 8'h02);
        lat(l0);
        chk(16'(l0 < 30), 16'h0001);
        xfer(0, 7'h1c, 8'h06);
        ext_pin = 1'b1;
        cyc(20);
        chk(sref, 0);
        clk1_in = 1'b1;
        cyc(20);
        chk(sref, 1);
        {ext_pin, clk1_in} = 2'h0;
        cyc(80);
        xfer(0, 7'h70, 8'h80);
        chk(busy, 0);
        $display("test external source done");
        d = $urandom_range(60, 1);
        n = $urandom_range(3, 2);
        xfer(0, 7'h1c, 8'h00);
        xfer(0, 7'h1b, d[7:0]);
        xfer(0, 7'h18, 8'h70);
        xfer(0, 7'h1a, n[7:0]);
        trig(n, 320, 1);
        xfer(0, 7'h1c, 8'h02);
        lat(l1);
        chk(16'(l1 - l0), 16'((d * 814 + 3999) / 4000));
        $display("test counted burst and delay done");
        xfer(0, 7'h1c, 8'h01);
        n = edges;
        xfer(0, 7'h70, 8'h80);
        chk(busy, 0);
        cyc(700);
        chk(16'(edges - n[15:0] >= 2), 16'h0001);
        // Leave continuous mode only in a low phase so no pulse is clipped
        for (int k = 0; k < 400 && sref !== 1'b1; k++) cyc(1);
        for (int k = 0; k < 400 && sref !== 1'b0; k++) cyc(1);
        xfer(0, 7'h1c, 8'h00);
        $display("test continuous done");
        xfer(0, 7'h19, 8'hd1);
        xfer(0, 7'h70, 8'h80);
        chk({pwr, busy}, 2'h0);
        xfer(1, 7'h19, 8'h00);
        chk(rd, 8'hd1);
        xfer(0, 7'h19, 8'h51);
        chk({pwr, xp}, 2'h2);
        force_idle = 1'b1;
        cyc(4);
        chk(xp, 1);
        xfer(0, 7'h19, 8'h11);
        chk(xp, 0);
        force_idle = 1'b0;
        $display("test power and bias done");
        conclude();
    end
endmodule
